// >>> hw/crg_core_regs.sv
// Programmer-visible control and address registers with arithmetic issue control.
// Assumes one instruction-stream client on a word operand port, one core clock.
`timescale 1ns/1ps
module crg_core_regs
  import crg_pkg::*;
#(
  parameter logic [23:0] OPMODE_DEFINED = OPMODE_MASK,   // Defined operating mode bits
  parameter int STACK_DEPTH = 16                         // System stack entries
) (
  input wire logic i_clk_sys,                 // Core clock, 40 MHz
  input wire logic i_rst_n,                   // Synchronous reset, active low
  input wire logic i_wr,                      // Word operand write strobe
  input wire logic [5:0] i_wsel,              // Write register selector
  input wire logic [23:0] i_wdata,            // Write data
  input wire logic [5:0] i_rsel,              // Read register selector
  output logic [23:0] o_rdata,                // Read data, registered
  input wire logic i_pc_load,                 // Implicit program counter load
  input wire logic [23:0] i_pc_next,          // Implicit next program counter
  input wire logic i_push_pc,                 // Push program counter and status
  input wire logic i_push_loop,               // Push loop end and loop counter
  input wire logic i_pop,                     // Pop top entry
  output logic [47:0] o_stack_top,            // Top stack entry, registered
  input wire logic [15:0] i_mem_word,         // X or Y memory word
  input wire logic i_byte_sign,               // Sign-extend a byte operand
  output logic [23:0] o_bus_byte,             // Extended byte on the data bus
  input wire logic [4:0] i_op,                // Arithmetic operation code
  input wire logic i_op_valid,                // Arithmetic operation issued
  input wire logic i_cond_en,                 // Conditional form
  input wire logic i_cond_true,               // Condition result
  input wire logic i_move_req,                // Parallel move requested
  input wire logic [7:0] i_alu_cc,            // Condition codes from the ALU
  output logic o_move_ok,                     // Parallel move granted
  output logic o_exec,                        // Operation executes
  output logic o_illegal,                     // Illegal move combination
  output logic o_alu_only_regs,               // ALU sources are registers only
  output logic [23:0] o_status,               // Status word, registered
  output logic [23:0] o_opmode                // Operating mode word, registered
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [23:0] agu_addr [AGU_COUNT];
  logic [23:0] agu_offs [AGU_COUNT];
  logic [23:0] agu_modf [AGU_COUNT];
  logic [23:0] opmode;
  logic [23:0] vector;
  logic [23:0] status;
  logic [23:0] loop_cnt;
  logic [23:0] loop_end;
  logic [23:0] stk_size;
  logic [23:0] stk_ptr;
  logic [23:0] prog_cnt;
  logic [47:0] stack_mem [STACK_DEPTH];
  logic [$clog2(STACK_DEPTH)-1:0] depth;
  wire logic [47:0] top_entry;
  wire logic cc_from_alu;
  wire logic [23:0] next_status;

  // ****************************************************************
  // Issue gate
  // ****************************************************************
  crg_op_gate u_gate (
    .i_op(i_op),
    .i_cond_en(i_cond_en),
    .i_cond_true(i_cond_true),
    .i_move_req(i_move_req && i_op_valid),
    .o_move_ok(o_move_ok),
    .o_exec(o_exec),
    .o_illegal(o_illegal)
  );

  // Data ALU never drives data buses
  assign o_alu_only_regs = 1'b1;
  // Condition codes load for every executing operation code; i_op is not decoded here
  assign cc_from_alu = i_op_valid && o_exec;

  // ****************************************************************
  // Status word update
  // ****************************************************************
  // Word write replaces all bytes
  // Byte writes touch one byte only
  assign next_status = (i_wr && i_wsel == SEL_STATUS) ? i_wdata :
                       (i_wr && i_wsel == SEL_MODE_BYTE) ?
                         {status[23:16], i_wdata[7:0], status[7:0]} :
                       (i_wr && i_wsel == SEL_CC_BYTE) ?
                         {status[23:8], i_wdata[7:0]} :
                       cc_from_alu ? {status[23:8], i_alu_cc} : status;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      status <= RESET_WORD;
    end else begin
      status <= next_status;
    end
  end

  // ****************************************************************
  // Word registers
  // ****************************************************************
  // Word writes to address generation set
  always_ff @(posedge i_clk_sys) begin
    for (int k = 0; k < AGU_COUNT; k++) begin
      if (!i_rst_n) begin
        agu_addr[k] <= RESET_WORD;
        agu_offs[k] <= RESET_WORD;
        agu_modf[k] <= RESET_WORD;
      end else if (i_wr) begin
        if (i_wsel == SEL_ADDR_BASE + 6'(k)) agu_addr[k] <= i_wdata;
        if (i_wsel == SEL_OFFS_BASE + 6'(k)) agu_offs[k] <= i_wdata;
        if (i_wsel == SEL_MODF_BASE + 6'(k)) agu_modf[k] <= i_wdata;
      end
    end
  end

  // Control words; reserved bits of opmode and vector are masked on entry so they read zero
  // Operating mode byte fields
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      opmode <= RESET_WORD;
      vector <= RESET_WORD;
      loop_cnt <= RESET_WORD;
      loop_end <= RESET_WORD;
      stk_size <= RESET_WORD;
    end else if (i_wr) begin
      if (i_wsel == SEL_OPMODE) opmode <= i_wdata & OPMODE_DEFINED;
      if (i_wsel == SEL_VECTOR) vector <= i_wdata & VECTOR_MASK;
      if (i_wsel == SEL_LOOP_CNT) loop_cnt <= i_wdata;
      if (i_wsel == SEL_LOOP_END) loop_end <= i_wdata;
      if (i_wsel == SEL_STK_SIZE) stk_size <= i_wdata;
    end
  end

  // Program addresses are full 24-bit words
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      prog_cnt <= RESET_WORD;
    end else if (i_wr && i_wsel == SEL_PROG_CNT) begin
      prog_cnt <= i_wdata;
    end else if (i_pc_load) begin
      prog_cnt <= i_pc_next;
    end
  end

  // ****************************************************************
  // System stack
  // ****************************************************************
  // Depth wraps silently; overflow detection is left to software via the pointer
  // Program counter and status pair, or loop end and counter pair
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      depth <= '0;
      stk_ptr <= RESET_WORD;
    end else if (i_push_pc || i_push_loop) begin
      stack_mem[depth + 1'b1] <= i_push_pc ? {prog_cnt, status} : {loop_end, loop_cnt};
      depth <= depth + 1'b1;
      stk_ptr <= stk_ptr + 24'h00_0001;
    end else if (i_pop) begin
      depth <= depth - 1'b1;
      stk_ptr <= stk_ptr - 24'h00_0001;
    end else if (i_wr && i_wsel == SEL_STK_PTR) begin
      stk_ptr <= i_wdata;
    end else if (i_wr && i_wsel == SEL_STK_UPPER) begin
      stack_mem[depth][47:24] <= i_wdata;
    end else if (i_wr && i_wsel == SEL_STK_LOWER) begin
      stack_mem[depth][23:0] <= i_wdata;
    end
  end
  assign top_entry = stack_mem[depth];

  // ****************************************************************
  // Byte extension and read mux
  // ****************************************************************
  // Zero or sign extension
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_bus_byte <= RESET_WORD;
    end else begin
      o_bus_byte <= {{16{i_byte_sign & i_mem_word[7]}}, i_mem_word[7:0]};
    end
  end

  // Read data registered one cycle after the selector
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= RESET_WORD;
    end else begin
      unique case (i_rsel) inside
        [SEL_ADDR_BASE:SEL_ADDR_BASE + 6'h07]: o_rdata <= agu_addr[i_rsel[2:0]];
        [SEL_OFFS_BASE:SEL_OFFS_BASE + 6'h07]: o_rdata <= agu_offs[i_rsel[2:0]];
        [SEL_MODF_BASE:SEL_MODF_BASE + 6'h07]: o_rdata <= agu_modf[i_rsel[2:0]];
        SEL_OPMODE: o_rdata <= opmode;
        SEL_VECTOR: o_rdata <= vector;
        SEL_STATUS: o_rdata <= status;
        SEL_MODE_BYTE: o_rdata <= {16'h0000, status[15:8]};
        SEL_CC_BYTE: o_rdata <= {16'h0000, status[7:0]};
        SEL_LOOP_CNT: o_rdata <= loop_cnt;
        SEL_LOOP_END: o_rdata <= loop_end;
        SEL_STK_SIZE: o_rdata <= stk_size;
        SEL_STK_UPPER: o_rdata <= top_entry[47:24];
        SEL_STK_LOWER: o_rdata <= top_entry[23:0];
        SEL_STK_PTR: o_rdata <= stk_ptr;
        SEL_PROG_CNT: o_rdata <= prog_cnt;
        default: o_rdata <= RESET_WORD;
      endcase
    end
  end

  // Registered views
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_stack_top <= 48'h0000_0000_0000;
    end else begin
      o_stack_top <= top_entry;
    end
  end
  assign o_status = status;
  assign o_opmode = opmode;

  // ****************************************************************
  // Checks
  // ****************************************************************
  status_word_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_wr && i_wsel == SEL_STATUS |=> status == $past(i_wdata))
    else $error("status word write lost");
  cc_byte_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_wr && i_wsel == SEL_CC_BYTE |=> status[23:8] == $past(status[23:8]))
    else $error("cc byte write disturbed upper bytes");
  opmode_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (opmode & ~OPMODE_DEFINED) == 24'h00_0000)
    else $error("reserved opmode bit set");
  cond_move_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_cond_en |-> !o_move_ok)
    else $error("conditional op got a move");
  par_refuse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_op_valid && i_move_req && i_op == OP_MULACC |-> o_illegal)
    else $error("plain accumulate accepted a move");
  par_accept_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_op_valid && i_move_req && !i_cond_en && i_op == OP_NEGATE |-> o_move_ok)
    else $error("negate refused a move");
  cond_skip_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_cond_en && !i_cond_true |-> !o_exec)
    else $error("false condition still executed");
  push_pair_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_push_pc && !i_pop ##1 !i_push_pc && !i_push_loop && !i_pop && !i_wr
    |=> o_stack_top == $past({prog_cnt, status}, 2))
    else $error("stack entry not program counter and status");
  byte_ext_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_byte_sign |=> o_bus_byte[23:8] == 16'h0000)
    else $error("zero extension failed");
  cc_update_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_op_valid && o_exec && !i_wr |=> status[7:0] == $past(i_alu_cc))
    else $error("condition codes not updated");
  cov_move: cover property (@(posedge i_clk_sys) o_move_ok);
  cov_cond_skip: cover property (@(posedge i_clk_sys) i_op_valid && !o_exec);
  cov_push_pop: cover property (@(posedge i_clk_sys) i_push_loop ##1 i_pop);

endmodule : crg_core_regs

// >>> hw/crg_pkg.sv
// Constants for the core register file and arithmetic group decoder.
// Assumes a single core clock and an instruction stream as the only register client.
package crg_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int WORD_W = 24;
  localparam int BYTE_W = 8;
  localparam int STACK_W = 48;
  localparam int AGU_COUNT = 8;

  // ****************************************************************
  // Register selector codes on the word operand port
  // ****************************************************************
  localparam logic [5:0] SEL_ADDR_BASE = 6'h00;   // address registers 0..7
  localparam logic [5:0] SEL_OFFS_BASE = 6'h08;   // offset registers 0..7
  localparam logic [5:0] SEL_MODF_BASE = 6'h10;   // modifier registers 0..7
  localparam logic [5:0] SEL_OPMODE = 6'h18;
  localparam logic [5:0] SEL_VECTOR = 6'h19;
  localparam logic [5:0] SEL_STATUS = 6'h1A;
  localparam logic [5:0] SEL_MODE_BYTE = 6'h1B;
  localparam logic [5:0] SEL_CC_BYTE = 6'h1C;
  localparam logic [5:0] SEL_LOOP_CNT = 6'h1D;
  localparam logic [5:0] SEL_LOOP_END = 6'h1E;
  localparam logic [5:0] SEL_STK_SIZE = 6'h1F;
  localparam logic [5:0] SEL_STK_UPPER = 6'h20;
  localparam logic [5:0] SEL_STK_LOWER = 6'h21;
  localparam logic [5:0] SEL_STK_PTR = 6'h22;
  localparam logic [5:0] SEL_PROG_CNT = 6'h23;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int CC_LSB = 0;
  localparam int MODE_LSB = 8;
  localparam int EXT_LSB = 16;
  localparam logic [23:0] OPMODE_MASK = 24'hFF_FFFF;  // defined bits, parameterised in top
  localparam logic [23:0] VECTOR_MASK = 24'hFF_FF00;
  localparam logic [23:0] RESET_WORD = 24'h00_0000;

  // ****************************************************************
  // Arithmetic operation codes
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_MAGNITUDE = 5'b0_0000, OP_ADD_CARRY = 5'b0_0001, OP_ADD = 5'b0_0010,
    OP_ADD_IMM = 5'b0_0011, OP_SHL_ADD = 5'b0_0100, OP_SHR_ADD = 5'b0_0101,
    OP_SHIFT_LEFT = 5'b0_0110, OP_SHIFT_LEFT_MB = 5'b0_0111, OP_SHIFT_RIGHT = 5'b0_1000,
    OP_SHIFT_RIGHT_MB = 5'b0_1001, OP_CLEAR = 5'b0_1010, OP_COMPARE = 5'b0_1011,
    OP_COMPARE_IMM = 5'b0_1100, OP_COMPARE_MAG = 5'b0_1101, OP_COMPARE_UNS = 5'b0_1110,
    OP_DEC = 5'b0_1111, OP_DIV = 5'b1_0000, OP_DOUBLE_MULACC = 5'b1_0001,
    OP_INC = 5'b1_0010, OP_MULACC = 5'b1_0011, OP_MULACC_MIX = 5'b1_0100,
    OP_MULACC_IMM = 5'b1_0101, OP_MULACC_RND = 5'b1_0110, OP_MULACC_RND_IMM = 5'b1_0111,
    OP_MAX = 5'b1_1000, OP_MAX_MAG = 5'b1_1001, OP_MULT = 5'b1_1010,
    OP_MULT_MIX = 5'b1_1011, OP_MULT_IMM = 5'b1_1100, OP_MULT_RND = 5'b1_1101,
    OP_NEGATE = 5'b1_1110, OP_FAST_NORM = 5'b1_1111
  } crg_op_t;

endpackage : crg_pkg

// >>> hw/crg_op_gate.sv
// Arithmetic issue gate: decides parallel-move legality and conditional execution.
// Assumes opcode, condition and move request are valid in the same cycle.
`timescale 1ns/1ps
module crg_op_gate
  import crg_pkg::*;
(
  input wire logic [4:0] i_op,          // Arithmetic operation code
  input wire logic i_cond_en,           // Operation carries a condition
  input wire logic i_cond_true,         // Condition evaluates true
  input wire logic i_move_req,          // Parallel move requested
  output logic o_move_ok,               // Parallel move may proceed
  output logic o_exec,                  // Operation executes
  output logic o_illegal                // Move request not allowed
);

  // ****************************************************************
  // Parallel move table
  // ****************************************************************
  wire logic par_capable;

  assign par_capable = (i_op == OP_SHL_ADD) || (i_op == OP_SHR_ADD) ||
                       (i_op == OP_SHIFT_LEFT) || (i_op == OP_SHIFT_RIGHT) ||
                       (i_op == OP_CLEAR) || (i_op == OP_COMPARE) ||
                       (i_op == OP_COMPARE_MAG) || (i_op == OP_MULACC_RND) ||
                       (i_op == OP_MAX) || (i_op == OP_MULT_RND) || (i_op == OP_NEGATE);

  assign o_exec = !i_cond_en || i_cond_true;
  assign o_move_ok = i_move_req && par_capable && !i_cond_en;
  assign o_illegal = i_move_req && !(par_capable && !i_cond_en);

endmodule : crg_op_gate

// >>> tb/testbench.sv
// Self-checking bench for the core register file and the arithmetic issue gate.
// Assumes crg_pkg and both design modules are compiled first; inputs change at falling edges.
`timescale 1ns/1ps
module testbench;
  import crg_pkg::*;

  logic i_clk_sys, i_rst_n, i_wr, i_pc_load, i_push_pc, i_push_loop, i_pop, i_byte_sign;
  logic i_op_valid, i_cond_en, i_cond_true, i_move_req;
  logic o_move_ok, o_exec, o_illegal, o_alu_only_regs;
  logic [5:0] i_wsel, i_rsel;
  logic [23:0] i_wdata, i_pc_next, o_rdata, o_bus_byte, o_status, o_opmode;
  logic [47:0] o_stack_top;
  logic [15:0] i_mem_word;
  logic [4:0] i_op;
  logic [7:0] i_alu_cc;
  logic [31:0] seed = 32'h0000_0005;
  logic [31:0] v, w;
  logic [23:0] stat_ref;
  int err_total = 0;
  int total_checks = 0;

  crg_core_regs crg_core_regs_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wr(i_wr),
    .i_wsel(i_wsel), .i_wdata(i_wdata), .i_rsel(i_rsel), .o_rdata(o_rdata),
    .i_pc_load(i_pc_load), .i_pc_next(i_pc_next), .i_push_pc(i_push_pc),
    .i_push_loop(i_push_loop), .i_pop(i_pop), .o_stack_top(o_stack_top),
    .i_mem_word(i_mem_word), .i_byte_sign(i_byte_sign), .o_bus_byte(o_bus_byte),
    .i_op(i_op), .i_op_valid(i_op_valid), .i_cond_en(i_cond_en), .i_cond_true(i_cond_true),
    .i_move_req(i_move_req), .i_alu_cc(i_alu_cc), .o_move_ok(o_move_ok), .o_exec(o_exec),
    .o_illegal(o_illegal), .o_alu_only_regs(o_alu_only_regs), .o_status(o_status),
    .o_opmode(o_opmode));

  // 40 MHz core clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // Repeatable xorshift stream
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Parallel move class: 1 allowed, 0 refused, 2 left open by the rules
  function automatic int par_class(input logic [4:0] op);
    case (op)
      OP_SHL_ADD, OP_SHR_ADD, OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_CLEAR, OP_COMPARE,
      OP_COMPARE_MAG, OP_MULACC_RND, OP_MAX, OP_MULT_RND, OP_NEGATE: return 1;
      OP_MAGNITUDE, OP_ADD, OP_MULACC, OP_MULT, OP_MULT_MIX: return 2;
      default: return 0;
    endcase
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Word write, taken at the next rising edge
  task automatic wr(input logic [5:0] sel, input logic [23:0] d);
    @(negedge i_clk_sys);
    i_wr = 1'b1;
    i_wsel = sel;
    i_wdata = d;
    @(negedge i_clk_sys);
    i_wr = 1'b0;
  endtask : wr

  // Registered read, data one cycle after the selector
  task automatic rd(input logic [5:0] sel, input logic [23:0] exp);
    i_rsel = sel;
    @(negedge i_clk_sys);
    chk(o_rdata, exp);
  endtask : rd

  // Stack strobe pulse, then the registered top entry
  task automatic stk(input logic [2:0] kind, input logic [47:0] exp);
    @(negedge i_clk_sys);
    i_push_pc = kind[0];
    i_push_loop = kind[1];
    i_pop = kind[2];
    @(negedge i_clk_sys);
    {i_pop, i_push_loop, i_push_pc} = 3'b000;
    @(negedge i_clk_sys);
    chk(o_stack_top, exp);
  endtask : stk

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Watchdog so a stuck run still reaches the report
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    err_total++;
    results();
  end

  initial begin
    {i_wr, i_pc_load, i_push_pc, i_push_loop, i_pop, i_byte_sign} = 6'b00_0000;
    {i_op_valid, i_cond_en, i_cond_true, i_move_req} = 4'b0000;
    i_rst_n = 1'b0;
    i_wsel = 6'h00;
    i_rsel = 6'h00;
    i_wdata = 24'h00_0000;
    i_pc_next = 24'h00_0000;
    i_mem_word = 16'h0000;
    i_op = 5'h00;
    i_alu_cc = 8'h00;
    repeat (12) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    chk(o_status, 24'h00_0000);
    chk(o_opmode, 24'h00_0000);
    chk(o_alu_only_regs, 1'b1);
    rd(6'h3F, 24'h00_0000);
    // Word registers: address, offset, modifier, loop, stack and counter words
    for (int r = 0; r < 3; r++) begin
      for (int s = 0; s < 29; s++) begin
        v = rnd();
        w = (s < 24) ? s : (s == 24) ? SEL_LOOP_CNT : (s == 25) ? SEL_LOOP_END :
            (s == 26) ? SEL_STK_SIZE : (s == 27) ? SEL_STK_PTR : SEL_PROG_CNT;
        if (r == 0) v[23:0] = 24'hFF_FFFF;
        wr(w[5:0], v[23:0]);
        rd(w[5:0], v[23:0]);
      end
      v = rnd();
      wr(SEL_OPMODE, v[23:0]);
      rd(SEL_OPMODE, v[23:0] & OPMODE_MASK);
      chk(o_opmode, {v[23:16], v[15:8], v[7:0]} & OPMODE_MASK);
      wr(SEL_VECTOR, v[31:8]);
      rd(SEL_VECTOR, v[31:8] & VECTOR_MASK);
    end
    // Status word, then the mode byte and the condition code byte alone
    stat_ref = 24'hA5_5AC3;
    wr(SEL_STATUS, stat_ref);
    chk(o_status, stat_ref);
    wr(SEL_MODE_BYTE, 24'hFF_FF12);
    chk(o_status, 24'hA5_12C3);
    wr(SEL_CC_BYTE, 24'hFF_FF3C);
    chk(o_status, 24'hA5_123C);
    // Issue gate over every code and condition and move combination
    for (int k = 0; k < 256; k++) begin
      @(negedge i_clk_sys);
      v = rnd();
      i_op = k[4:0];
      i_cond_en = k[5];
      i_cond_true = k[6];
      i_move_req = k[7];
      i_op_valid = 1'b1;
      i_alu_cc = v[7:0];
      #1;
      chk(o_exec, !k[5] || k[6]);
      if (par_class(k[4:0]) != 2) begin
        w[0] = (par_class(k[4:0]) == 1) && !k[5];
        chk(o_move_ok, k[7] && w[0]);
        chk(o_illegal, k[7] && !w[0]);
      end
    end
    // Condition codes follow the ALU only when the operation executes
    for (int k = 0; k < 3; k++) begin
      wr(SEL_STATUS, stat_ref);
      v = rnd();
      i_op = OP_ADD;
      i_cond_en = (k != 0);
      i_cond_true = (k == 2);
      i_alu_cc = v[7:0];
      i_op_valid = 1'b1;
      @(negedge i_clk_sys);
      i_op_valid = 1'b0;
      @(negedge i_clk_sys);
      chk(o_status, (k == 1) ? stat_ref : {stat_ref[23:8], v[7:0]});
    end
    // Byte operand extension, sign bit forced high in the first passes
    for (int k = 0; k < 20; k++) begin
      v = rnd();
      if (k < 3) v[7] = 1'b1;
      @(negedge i_clk_sys);
      i_mem_word = v[15:0];
      i_byte_sign = v[16];
      @(negedge i_clk_sys);
      chk(o_bus_byte, v[16] ? {{16{v[7]}}, v[7:0]} : {16'h0000, v[7:0]});
    end
    // Implicit counter load, then an explicit write in the same cycle wins
    @(negedge i_clk_sys);
    i_pc_load = 1'b1;
    i_pc_next = 24'h12_3456;
    @(negedge i_clk_sys);
    i_pc_load = 1'b0;
    rd(SEL_PROG_CNT, 24'h12_3456);
    i_pc_load = 1'b1;
    i_pc_next = 24'h65_4321;
    wr(SEL_PROG_CNT, 24'h00_0ABC);
    i_pc_load = 1'b0;
    rd(SEL_PROG_CNT, 24'h00_0ABC);
    // System stack: counter with status, then loop words, then pop
    wr(SEL_STK_PTR, 24'h00_0000);
    wr(SEL_STATUS, stat_ref);
    wr(SEL_LOOP_END, 24'hBE_EF01);
    wr(SEL_LOOP_CNT, 24'h00_0100);
    stk(3'b001, {24'h00_0ABC, stat_ref});
    stk(3'b010, 48'hBE_EF01_00_0100);
    rd(SEL_STK_UPPER, 24'hBE_EF01);
    rd(SEL_STK_LOWER, 24'h00_0100);
    stk(3'b100, {24'h00_0ABC, stat_ref});
    results();
  end
endmodule : testbench
